// [event_src_if.sv]
// Purpose: qualified event sources passed from the tracker to the counter logic
// Assumes: single core clock domain
// Notes: none
`timescale 1ns/1ps
interface event_src_if #(parameter int OUTST_W = 4);
	logic               unhalted;
	logic               other_halted;
	logic [OUTST_W-1:0] outstanding;
	modport tracker (output unhalted, output other_halted, output outstanding);
	modport counter (input unhalted, input other_halted, input outstanding);
endinterface

// [evt_source.sv]
// Purpose: random core, halt and bus event pulses for the counter bench
// Assumes: halt and wake are one-cycle pulses; other halted is a toggled level; the rest are drawn afresh each cycle
// Notes: ev_o = halt, wake, other halted, bus tick, read, write, issue, done
`timescale 1ns/1ps
module evt_source
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	output logic      [7:0] ev_o
);
	bit        halt_instruction;
	int        pend;
	bit [31:0] r;
	always @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			ev_o <= 8'h00;
			halt_instruction = 1'b0;
			pend = 0;
		end
		else
		begin
			r = $urandom;
			halt_instruction = ev_o[7] || (halt_instruction && !ev_o[6]);
			pend = pend + ev_o[1] - ev_o[0];
			// halt only while running and wake only while halted, as a real core would
			ev_o[7] <= !halt_instruction && r[4:0] == 5'h00;
			ev_o[6] <= halt_instruction && r[7:5] == 3'h0;
			ev_o[5] <= ev_o[5] ^ (r[11:8] == 4'h0);
			ev_o[4] <= r[13:12] == 2'h0;
			ev_o[3:2] <= r[15:14];
			// pending reads stay below the saturation point of the tracker
			ev_o[1] <= pend < 12 && r[17:16] == 2'h0;
			ev_o[0] <= pend > 0 && r[19:18] == 2'h0;
		end
endmodule

// [outstanding_tracker.sv]
// Purpose: halt state of this core and count of pending full-line bus reads
// Assumes: issue and completion are one-cycle pulses on the core clock
// Notes: count saturates at both ends rather than wrapping
`timescale 1ns/1ps
`include "perf_event_cfg.svh"
module outstanding_tracker #(parameter int OUTST_W = 4)
(
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  halt_exec_i,
	input  wire logic  wake_i,
	input  wire logic  other_halted_i,
	input  wire logic  line_read_issue_i,
	input  wire logic  line_read_done_i,
	event_src_if.tracker src
);
	perf_event_pkg::core_state_type state_q;
	logic [OUTST_W-1:0]             outst_q;

	// ******************************
	// halt state
	// ******************************
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= perf_event_pkg::RUN_ST;
		else
		begin
			unique case (state_q)
				perf_event_pkg::RUN_ST:
					if (halt_exec_i)
						state_q <= perf_event_pkg::HALT_ST;
				perf_event_pkg::HALT_ST:
					if (wake_i)
						state_q <= perf_event_pkg::RUN_ST;
			endcase
		end
	end

	// ******************************
	// outstanding reads
	// ******************************
	// pending from the issue cycle until the full line is in
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			outst_q <= `OUTST_RESET;
		else if (line_read_issue_i && !line_read_done_i && outst_q != {OUTST_W{1'b1}})
			outst_q <= outst_q + OUTST_W'(`OUTST_ONE);
		else if (!line_read_issue_i && line_read_done_i && outst_q != '0)
			outst_q <= outst_q - OUTST_W'(`OUTST_ONE);
	end

	// issue pulse counts in its own cycle, done pulse no longer counts;
	// a lone issue at the full count is dropped so the sum cannot wrap to zero
	assign src.outstanding  = outst_q
		+ OUTST_W'(line_read_issue_i && (outst_q != {OUTST_W{1'b1}} || line_read_done_i))
		- OUTST_W'(line_read_done_i && outst_q != '0);
	// halt counts from the cycle the halt instruction executes
	assign src.unhalted     = (state_q == perf_event_pkg::RUN_ST) && !halt_exec_i;
	assign src.other_halted = other_halted_i;
endmodule

// [perf_event_cfg.svh]
// Purpose: constants for the event-select counter block
// Assumes: core clock 200 MHz, single clock domain
// Notes: event codes and unit masks as encoded in the select fields
`ifndef PERF_EVENT_CFG_SVH
`define PERF_EVENT_CFG_SVH

`define EVT_UNHALTED        8'h3C
`define EVT_CACHE_ACCESS    8'h40
`define EVT_BUS_OUTSTANDING 8'h60
`define UMASK_CORE          8'h00
`define UMASK_BUS           8'h01
`define UMASK_SOLE          8'h02
`define UMASK_READ          8'h21
`define UMASK_WRITE         8'h22
`define CNT_RESET           48'h0000_0000_0000
`define OUTST_RESET         4'h0
`define OUTST_ONE           4'h1
`define FLAG_RESET          1'b0

`endif

// [perf_event_checker.sv]
// Purpose: concurrent checks on the event counter ports
// Assumes: one core clock, asynchronous active-low reset
// Notes: only programmable counter 0 is watched here, to stay small
`timescale 1ns/1ps
module perf_event_checker #(parameter int CNT_W = 48, parameter int RATIO_W = 8)
(
	input  wire logic               CORE_CLK_I,
	input  wire logic               RST_N_I,
	input  wire logic [7:0]         EVT0_CODE_I,
	input  wire logic [7:0]         EVT0_MASK_I,
	input  wire logic               EVT0_EN_I,
	input  wire logic               FIXED_EN_I,
	input  wire logic [RATIO_W-1:0] MAX_RATIO_I,
	input  wire logic               HALT_EXEC_I,
	input  wire logic               WAKE_I,
	input  wire logic               OTHER_HALTED_I,
	input  wire logic               BUS_TICK_I,
	input  wire logic               CACHE_RD_I,
	input  wire logic               CACHE_WR_I,
	input  wire logic [CNT_W-1:0]   PMC0_O,
	input  wire logic [CNT_W-1:0]   UNHALTED_CORE_CYCLES_FIXED_O,
	input  wire logic [CNT_W-1:0]   UNHALTED_REFERENCE_CYCLES_O
);
	logic             hq;
	logic             run_q;
	logic             unh;
	logic             s3c;
	logic             s40;
	logic [CNT_W-1:0] p0;
	logic [CNT_W-1:0] fx;
	logic [CNT_W-1:0] rf;
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
			hq <= 1'b0;
		else
			hq <= HALT_EXEC_I | (hq & !WAKE_I);
	// the release edge still samples reset-time values, so checking starts one edge later
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
			run_q <= 1'b0;
		else
			run_q <= 1'b1;
	// the halt-executing cycle is already halted; the wake cycle still is
	assign unh = !hq && !HALT_EXEC_I;
	assign s3c = EVT0_EN_I && EVT0_CODE_I == 8'h3C;
	assign s40 = EVT0_EN_I && EVT0_CODE_I == 8'h40;
	assign p0 = PMC0_O;
	assign fx = UNHALTED_CORE_CYCLES_FIXED_O;
	assign rf = UNHALTED_REFERENCE_CYCLES_O;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I || !run_q);
	a_fixed_core_count: assert property (FIXED_EN_I && unh |=> fx == $past(fx) + 1)
		else $error("fixed counter missed a running cycle");
	a_halt_stops_fixed: assert property (!unh |=> $stable(fx))
		else $error("fixed counter moved while halted");
	a_pmc_core_cycles: assert property (s3c && EVT0_MASK_I == 8'h00 && unh |=>
		p0 == $past(p0) + 1)
		else $error("core cycle event missed");
	a_pmc_bus_cycles: assert property (s3c && EVT0_MASK_I == 8'h01 |=>
		p0 == $past(p0) + $past(BUS_TICK_I && unh))
		else $error("bus cycle event wrong");
	a_pmc_sole_core: assert property (s3c && EVT0_MASK_I == 8'h02 |=>
		p0 == $past(p0) + $past(BUS_TICK_I && unh && OTHER_HALTED_I))
		else $error("sole core event wrong");
	a_pmc_cache_read: assert property (s40 && EVT0_MASK_I == 8'h21 |=>
		p0 == $past(p0) + $past(CACHE_RD_I))
		else $error("cacheable read event wrong");
	a_pmc_cache_write: assert property (s40 && EVT0_MASK_I == 8'h22 |=>
		p0 == $past(p0) + $past(CACHE_WR_I))
		else $error("cacheable write event wrong");
	a_pmc_no_match: assert property (!EVT0_EN_I
		|| !(EVT0_CODE_I inside {8'h3C, 8'h40, 8'h60}) |=> $stable(p0))
		else $error("counter moved without a matching event");
	a_ref_ratio_step: assert property (BUS_TICK_I && unh |=>
		rf == $past(rf) + $past(MAX_RATIO_I))
		else $error("reference count step not equal to ratio");
endmodule
bind perf_event_counter_select perf_event_checker #(.CNT_W(CNT_W), .RATIO_W(RATIO_W)) chk (.*);

// [perf_event_counter_select.sv]
// Purpose: programmable and fixed event counters for one core
// Assumes: all inputs synchronous to CORE_CLK_I; bus tick is a one-cycle pulse
// Notes: counters wrap; no overflow signalling
// Overview of operation
// - code 3CH mask 00H counts core cycles while core is not halted.
// - core is halted from halt instruction execution; unhalted events stop meanwhile.
// - code 3CH mask 01H counts bus cycles while core is not halted.
// - code 3CH mask 02H counts bus cycles with this core running, other halted.
// - code 40H mask 21H counts cacheable data reads.
// - code 40H mask 22H counts cacheable data writes.
// - code 60H adds the number of outstanding full-line reads each cycle.
// - a line read is outstanding from bus issue until the full line arrives.
// - outstanding reads count is thread independent, regardless of all-threads qualifier.
// - a fixed counter also counts unhalted core cycles; programmable stays selectable.
// - unhalted bus cycles times max frequency ratio equals reference cycle count.
`timescale 1ns/1ps
`include "perf_event_cfg.svh"
module perf_event_counter_select #(
	parameter int CNT_W   = 48,
	parameter int OUTST_W = 4,
	parameter int RATIO_W = 8
)
(
	input  wire logic               CORE_CLK_I,
	input  wire logic               RST_N_I,
	input  wire logic [7:0]         EVT0_CODE_I,
	input  wire logic [7:0]         EVT0_MASK_I,
	input  wire logic               EVT0_EN_I,
	input  wire logic               EVT0_ALL_THREADS_I,
	input  wire logic [7:0]         EVT1_CODE_I,
	input  wire logic [7:0]         EVT1_MASK_I,
	input  wire logic               EVT1_EN_I,
	input  wire logic               EVT1_ALL_THREADS_I,
	input  wire logic               FIXED_EN_I,
	input  wire logic [RATIO_W-1:0] MAX_RATIO_I,
	input  wire logic               HALT_EXEC_I,
	input  wire logic               WAKE_I,
	input  wire logic               OTHER_HALTED_I,
	input  wire logic               BUS_TICK_I,
	input  wire logic               CACHE_RD_I,
	input  wire logic               CACHE_WR_I,
	input  wire logic               LINE_READ_ISSUE_I,
	input  wire logic               LINE_READ_DONE_I,
	output logic [CNT_W-1:0]        PMC0_O,
	output logic [CNT_W-1:0]        PMC1_O,
	output logic [CNT_W-1:0]        UNHALTED_CORE_CYCLES_FIXED_O,
	output logic [CNT_W-1:0]        UNHALTED_REFERENCE_CYCLES_O,
	output logic                    CORE_UNHALTED_O
);
	event_src_if #(.OUTST_W(OUTST_W)) src ();

	logic [CNT_W-1:0] pmc0_q;
	logic [CNT_W-1:0] pmc1_q;
	logic [CNT_W-1:0] fixed_q;
	logic [CNT_W-1:0] ref_q;
	logic             unhalted_q;
	logic [CNT_W-1:0] inc0;
	logic [CNT_W-1:0] inc1;

	outstanding_tracker #(.OUTST_W(OUTST_W)) u_tracker
	(
		.clk_i             (CORE_CLK_I),
		.rst_n_i           (RST_N_I),
		.halt_exec_i       (HALT_EXEC_I),
		.wake_i            (WAKE_I),
		.other_halted_i    (OTHER_HALTED_I),
		.line_read_issue_i (LINE_READ_ISSUE_I),
		.line_read_done_i  (LINE_READ_DONE_I),
		.src               (src)
	);

	// ******************************
	// event selection
	// ******************************
	// the all-threads bit is accepted but ignored: one count per core either way
	function automatic logic [CNT_W-1:0] event_inc
	(
		input logic [7:0]         code,
		input logic [7:0]         mask,
		input logic               en,
		input logic               all_thr,
		input logic               unh,
		input logic               oth,
		input logic               tick,
		input logic               rd,
		input logic               wr,
		input logic [OUTST_W-1:0] outst
	);
		logic [CNT_W-1:0] r;
		r = '0;
		if (en)
		begin
			if (code == `EVT_UNHALTED && mask == `UMASK_CORE)
				r = CNT_W'(unh);
			else if (code == `EVT_UNHALTED && mask == `UMASK_BUS)
				r = CNT_W'(unh && tick);
			else if (code == `EVT_UNHALTED && mask == `UMASK_SOLE)
				r = CNT_W'(unh && oth && tick);
			else if (code == `EVT_CACHE_ACCESS && mask == `UMASK_READ)
				r = CNT_W'(rd);
			else if (code == `EVT_CACHE_ACCESS && mask == `UMASK_WRITE)
				r = CNT_W'(wr);
			else if (code == `EVT_BUS_OUTSTANDING)
				r = CNT_W'(outst) | CNT_W'(all_thr & 1'b0);
		end
		return r;
	endfunction

	assign inc0 = event_inc(EVT0_CODE_I, EVT0_MASK_I, EVT0_EN_I, EVT0_ALL_THREADS_I,
		src.unhalted, src.other_halted, BUS_TICK_I, CACHE_RD_I, CACHE_WR_I,
		src.outstanding);
	assign inc1 = event_inc(EVT1_CODE_I, EVT1_MASK_I, EVT1_EN_I, EVT1_ALL_THREADS_I,
		src.unhalted, src.other_halted, BUS_TICK_I, CACHE_RD_I, CACHE_WR_I,
		src.outstanding);

	// ******************************
	// programmable counters
	// ******************************
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			pmc0_q <= `CNT_RESET;
		else
			pmc0_q <= pmc0_q + inc0;
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			pmc1_q <= `CNT_RESET;
		else
			pmc1_q <= pmc1_q + inc1;
	end

	// ******************************
	// fixed counters
	// ******************************
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			fixed_q <= `CNT_RESET;
		else if (FIXED_EN_I && src.unhalted)
			fixed_q <= fixed_q + CNT_W'(1'b1);
	end

	// reference steps by the max ratio per unhalted bus tick, so the ratio is exact
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			ref_q <= `CNT_RESET;
		else if (src.unhalted && BUS_TICK_I)
			ref_q <= ref_q + CNT_W'(MAX_RATIO_I);
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			unhalted_q <= `FLAG_RESET;
		else
			unhalted_q <= src.unhalted;
	end

	assign PMC0_O                       = pmc0_q;
	assign PMC1_O                       = pmc1_q;
	assign UNHALTED_CORE_CYCLES_FIXED_O = fixed_q;
	assign UNHALTED_REFERENCE_CYCLES_O  = ref_q;
	assign CORE_UNHALTED_O              = unhalted_q;
endmodule

// [perf_event_counter_select_tb.sv]
// Purpose: self-checking bench for the event counter block
// Assumes: the partner model drives all event pulses at random
// Notes: an integer model follows every cycle and is compared at each falling edge
`timescale 1ns/1ps
module perf_event_counter_select_tb;
	logic        CORE_CLK_I = 1'b0;
	logic        RST_N_I = 1'b0;
	logic [7:0]  EVT0_CODE_I, EVT0_MASK_I, EVT1_CODE_I, EVT1_MASK_I, MAX_RATIO_I;
	logic        EVT0_EN_I, EVT0_ALL_THREADS_I, EVT1_EN_I, EVT1_ALL_THREADS_I, FIXED_EN_I;
	logic        HALT_EXEC_I, WAKE_I, OTHER_HALTED_I, BUS_TICK_I, CACHE_RD_I, CACHE_WR_I;
	logic        LINE_READ_ISSUE_I, LINE_READ_DONE_I, CORE_UNHALTED_O;
	logic [47:0] PMC0_O, PMC1_O, UNHALTED_CORE_CYCLES_FIXED_O, UNHALTED_REFERENCE_CYCLES_O;
	logic [15:0] sel [8] = '{16'h3C00, 16'h3C01, 16'h3C02, 16'h4021, 16'h4022, 16'h6000,
		16'h6077, 16'h3C21};
	longint      e0, e1, ef, er, eu, pq;
	bit          hq, unh;
	bit   [31:0] r;
	int          fails = 0;
	int          n_tests = 0;
	always #2.5 CORE_CLK_I = !CORE_CLK_I;
	perf_event_counter_select dut (.*);
	evt_source src (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I), .ev_o({HALT_EXEC_I, WAKE_I,
		OTHER_HALTED_I, BUS_TICK_I, CACHE_RD_I, CACHE_WR_I, LINE_READ_ISSUE_I, LINE_READ_DONE_I}));
	function automatic longint inc(logic [15:0] s, logic en);
		if (!en)
			return 0;
		case (s)
			16'h3C00: return unh;
			16'h3C01: return BUS_TICK_I && unh;
			16'h3C02: return BUS_TICK_I && unh && OTHER_HALTED_I;
			16'h4021: return CACHE_RD_I;
			16'h4022: return CACHE_WR_I;
			default: return s[15:8] == 8'h60 ? pq : 0;
		endcase
	endfunction
	always @(posedge CORE_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			{e0, e1, ef, er, eu, pq} = 0;
			hq = 1'b0;
		end
		else
		begin
			unh = !hq && !HALT_EXEC_I;
			pq = pq + LINE_READ_ISSUE_I - LINE_READ_DONE_I;
			e0 += inc({EVT0_CODE_I, EVT0_MASK_I}, EVT0_EN_I);
			e1 += inc({EVT1_CODE_I, EVT1_MASK_I}, EVT1_EN_I);
			ef += FIXED_EN_I && unh;
			er += (BUS_TICK_I && unh) ? MAX_RATIO_I : 0;
			eu = unh;
			hq = HALT_EXEC_I || (hq && !WAKE_I);
		end
	task automatic check(string n, logic [47:0] seen, longint exp);
		n_tests++;
		if (seen !== 48'(exp))
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, 48'(exp), seen);
		end
	endtask
	always @(negedge CORE_CLK_I)
	begin
		check("pmc0", PMC0_O, e0);
		check("pmc1", PMC1_O, e1);
		check("fixed", UNHALTED_CORE_CYCLES_FIXED_O, ef);
		check("reference", UNHALTED_REFERENCE_CYCLES_O, er);
		check("unhalted", 48'(CORE_UNHALTED_O), eu);
	end
	task automatic stop_test;
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h816d_d546));
		{EVT0_CODE_I, EVT0_MASK_I, EVT1_CODE_I, EVT1_MASK_I, MAX_RATIO_I} = 0;
		{EVT0_EN_I, EVT0_ALL_THREADS_I, EVT1_EN_I, EVT1_ALL_THREADS_I, FIXED_EN_I} = 0;
		repeat (10) @(posedge CORE_CLK_I);
		// second half runs with random enables and one reset in mid-run
		for (int i = 0; i < 16; i++)
		begin
			r = $urandom;
			{EVT0_CODE_I, EVT0_MASK_I} <= sel[i % 8];
			{EVT1_CODE_I, EVT1_MASK_I} <= sel[(i + 3) % 8];
			{EVT0_EN_I, EVT1_EN_I} <= r[1:0] | {i < 8, i < 8};
			{EVT0_ALL_THREADS_I, EVT1_ALL_THREADS_I} <= r[3:2];
			FIXED_EN_I <= r[4] | (i < 8);
			MAX_RATIO_I <= r[15:8];
			RST_N_I <= i != 12;
			repeat (300) @(posedge CORE_CLK_I);
		end
		stop_test;
	end
	initial
	begin
		#(16 * 300 * 5 + 1000);
		fails++;
		stop_test;
	end
endmodule

// [perf_event_pkg.sv]
// Purpose: types shared by the event-select counter block
// Assumes: nothing beyond the cfg header
// Notes: none
package perf_event_pkg;
	typedef enum logic [1:0]
	{
		RUN_ST  = 2'b00,
		HALT_ST = 2'b01
	} core_state_type;
endpackage
